// File: dtdo_pkg.sv
package dtdo_pkg;

  // register byte addresses on the 32-bit bus, data in the low byte
  localparam logic [7:0] PORT_CFG_OFS = 8'h00;
  localparam logic [7:0] SHORT_CTRL_OFS = 8'h04;
  localparam logic [7:0] MODE_CTRL_OFS = 8'h08;
  localparam logic [7:0] LONG_CTRL_OFS = 8'h0c;
  localparam logic [7:0] CAP_HIGH_OFS = 8'h10;
  localparam logic [7:0] CAP_LOW_OFS = 8'h14;
  localparam logic [7:0] RELOAD_LOW_OFS = 8'h18;
  localparam logic [7:0] RELOAD_HIGH_OFS = 8'h1c;
  localparam logic [7:0] SHORT_RELOAD_OFS = 8'h20;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h24;
  localparam logic [7:0] IRQ_PEND_OFS = 8'h28;

  // short and long timer control fields
  localparam int EN_BIT = 7;
  localparam int SINGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int SHORT_INT_BIT = 1;
  localparam int LONG_INT_BIT = 2;
  localparam int PIN_BIT = 0;
  // mode control fields
  localparam int DEMOD_BIT = 7;
  localparam int COMBINE_BIT = 6;
  localparam int LOGIC_LO = 4;
  localparam int SUB_LO = 2;
  localparam int RISE_BIT = 1;
  localparam int FALL_BIT = 0;
  // port configuration and interrupt mask fields
  localparam int COMP_ROUTE_BIT = 0;
  localparam int IRQ_GLOBAL_BIT = 7;
  localparam int IRQ_NUM = 6;
  localparam int IRQ_SHORT = 4;
  localparam int IRQ_LONG = 5;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RELOAD8_RST = 8'hff;
  localparam logic [15:0] LONG_ALL_ONES = 16'hffff;

  localparam logic [1:0] LOGIC_AND = 2'h0;
  localparam logic [1:0] LOGIC_OR = 2'h1;
  localparam logic [1:0] LOGIC_NOR = 2'h2;
  localparam logic [1:0] LOGIC_NAND = 2'h3;
  localparam logic [1:0] SUB_PING_PONG = 2'h1;
  localparam logic [1:0] SUB_FORCE_LOW = 2'h2;
  localparam logic [1:0] SUB_FORCE_HIGH = 2'h3;
  localparam logic [1:0] EDGE_FALLING = 2'h0;
  localparam logic [1:0] EDGE_RISING = 2'h1;

  typedef enum logic [2:0] {
    DTDO_L_IDLE = 3'b001,
    DTDO_L_ARMED = 3'b010,
    DTDO_L_RUN = 3'b100
  } dtdo_lstate_t;

  // sticky status: a set in the same cycle as the clear wins
  function automatic logic dtdo_w1c(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : dtdo_w1c

  function automatic logic dtdo_logic(input logic [1:0] sel, input logic a, input logic b);
    logic r;
    r = 1'b0;
    case (sel)
      LOGIC_AND: r = a & b;
      LOGIC_OR: r = a | b;
      LOGIC_NOR: r = ~(a | b);
      default: r = ~(a & b);
    endcase
    return r;
  endfunction : dtdo_logic

endpackage : dtdo_pkg

// File: dtdo_sync.sv
`timescale 1ns/1ps
module dtdo_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // core clock
  input wire logic rst_n_i, // async reset, active low
  input wire logic [W-1:0] d_i, // asynchronous pin levels
  output logic [W-1:0] q_o, // synchronised levels
  output logic [W-1:0] rise_o, // one-cycle rising edge pulse
  output logic [W-1:0] fall_o // one-cycle falling edge pulse
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  // edges are taken from the second and third stage only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign q_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;
  assign fall_o = ~sync_reg & last_reg;

endmodule : dtdo_sync

// File: dtdo_top.sv
// How it works
// - in capture mode 0, a later selected edge stores the inverted count in capture bytes
// - each capture sets the rising or falling status bit and requests an interrupt if enabled
// - after each capture the long counter reloads all ones and keeps counting, or stops if the single bit is set
// - ping-pong: hardware toggles both enables so exactly one counter runs
// - ping-pong: each counter sets its timeout bit at every terminal count
// - short pin output bit routes the short counter output to its port pin unless port configuration bit 0 is set
// - long pin output bit routes the long counter output to its port pin
// - combine bit drives the third pin with both outputs combined by the logic field
// - six interrupt requests, two from the timers, masked singly and globally
// - port configuration bit 0 routes comparator outputs to two pins, else normal port
// - demodulation: first selected edge after enable reloads all ones and starts counting
// - demodulation edge status stays set until software writes a one to it
// - transmit mode combines outputs by and, or, nor or nand per logic field
// - timeout bits stay set until a one is written; writing zero does nothing
`timescale 1ns/1ps
module dtdo_top (
  input wire logic CORE_CLK_I, // 200 MHz core clock
  input wire logic RESETN_I, // async reset, active low
  input wire logic [7:0] AVS_ADDRESS_I, // byte address
  input wire logic AVS_READ_I, // read request
  input wire logic AVS_WRITE_I, // write request
  input wire logic [31:0] AVS_WRITEDATA_I, // write data, low byte used
  input wire logic [3:0] AVS_BYTEENABLE_I, // lane 0 gates writes
  output logic [31:0] AVS_READDATA_O, // read data
  output logic AVS_WAITREQUEST_O, // stall
  input wire logic CARRIER_I, // modulated carrier pin
  input wire logic [1:0] COMP_I, // comparator outputs
  input wire logic [2:0] PORT3_IRQ_I, // port 3 interrupt pins
  input wire logic LOW_VOLT_I, // low voltage detect
  input wire logic [3:0] PORT_OUT_I, // normal port output data
  output logic SHORT_TIMER_PIN_O, // pin shared with short counter
  output logic LONG_TIMER_PIN_O, // pin shared with long counter
  output logic COMBINED_TIMER_PIN_O, // pin for combined outputs
  output logic COMPARATOR_SECOND_PIN_O, // pin for second comparator
  output logic [5:0] IRQ_O // masked interrupt requests
);

  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0] rd_mux;
  logic [7:0] wdata8;
  logic wr_en;
  logic wr_stc, wr_mode, wr_ltc;
  logic [7:0] port_cfg_reg;
  logic [7:0] short_ctrl_reg, short_ctrl_next;
  logic [7:0] mode_ctrl_reg, mode_ctrl_next;
  logic [7:0] long_ctrl_reg, long_ctrl_next;
  logic [15:0] cap_reg;
  logic [15:0] reload16_reg;
  logic [7:0] short_reload_reg;
  logic [7:0] irq_mask_reg;
  logic [7:0] short_cnt_reg;
  logic short_run_reg;
  logic short_out_reg;
  logic [15:0] long_cnt_reg;
  logic [15:0] long_cnt_inv;
  logic long_out_reg;
  dtdo_pkg::dtdo_lstate_t lstate_reg;
  logic [6:0] pin_sync, pin_rise, pin_fall;
  logic [5:0] irq_src;
  logic demod, pp_mode, edge_hit, cap_evt;
  logic s_tc, l_zero, l_tc, long_val, combo;

  dtdo_sync #(
    .W(7)
  ) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RESETN_I),
    .d_i({LOW_VOLT_I, PORT3_IRQ_I, COMP_I, CARRIER_I}),
    .q_o(pin_sync),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // one wait state per request keeps the read mux off the bus path
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end
    else
    begin
      wait_reg <= ~((AVS_READ_I | AVS_WRITE_I) & wait_reg);
      if (AVS_READ_I && wait_reg)
        rdata_reg <= {24'h000000, rd_mux};
    end
  end

  assign wdata8 = AVS_WRITEDATA_I[7:0];
  assign wr_en = AVS_WRITE_I & ~wait_reg & AVS_BYTEENABLE_I[0];
  assign wr_stc = wr_en & (AVS_ADDRESS_I == dtdo_pkg::SHORT_CTRL_OFS);
  assign wr_mode = wr_en & (AVS_ADDRESS_I == dtdo_pkg::MODE_CTRL_OFS);
  assign wr_ltc = wr_en & (AVS_ADDRESS_I == dtdo_pkg::LONG_CTRL_OFS);

  // port configuration is write only and reads back zero
  always_comb
  begin
    rd_mux = 8'h00;
    if (AVS_ADDRESS_I == dtdo_pkg::SHORT_CTRL_OFS)
      rd_mux = short_ctrl_reg;
    else if (AVS_ADDRESS_I == dtdo_pkg::MODE_CTRL_OFS)
      rd_mux = mode_ctrl_reg;
    else if (AVS_ADDRESS_I == dtdo_pkg::LONG_CTRL_OFS)
      rd_mux = long_ctrl_reg;
    else if (AVS_ADDRESS_I == dtdo_pkg::CAP_HIGH_OFS)
      rd_mux = cap_reg[15:8];
    else if (AVS_ADDRESS_I == dtdo_pkg::CAP_LOW_OFS)
      rd_mux = cap_reg[7:0];
    else if (AVS_ADDRESS_I == dtdo_pkg::RELOAD_LOW_OFS)
      rd_mux = reload16_reg[7:0];
    else if (AVS_ADDRESS_I == dtdo_pkg::RELOAD_HIGH_OFS)
      rd_mux = reload16_reg[15:8];
    else if (AVS_ADDRESS_I == dtdo_pkg::SHORT_RELOAD_OFS)
      rd_mux = short_reload_reg;
    else if (AVS_ADDRESS_I == dtdo_pkg::IRQ_MASK_OFS)
      rd_mux = irq_mask_reg;
    else if (AVS_ADDRESS_I == dtdo_pkg::IRQ_PEND_OFS)
      rd_mux = {2'h0, irq_src};
  end

  // plain storage registers
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      port_cfg_reg <= dtdo_pkg::CTRL_RST;
      reload16_reg <= dtdo_pkg::LONG_ALL_ONES;
      short_reload_reg <= dtdo_pkg::RELOAD8_RST;
      irq_mask_reg <= dtdo_pkg::CTRL_RST;
    end
    else if (wr_en)
    begin
      if (AVS_ADDRESS_I == dtdo_pkg::PORT_CFG_OFS)
        port_cfg_reg <= wdata8;
      else if (AVS_ADDRESS_I == dtdo_pkg::RELOAD_LOW_OFS)
        reload16_reg[7:0] <= wdata8;
      else if (AVS_ADDRESS_I == dtdo_pkg::RELOAD_HIGH_OFS)
        reload16_reg[15:8] <= wdata8;
      else if (AVS_ADDRESS_I == dtdo_pkg::SHORT_RELOAD_OFS)
        short_reload_reg <= wdata8;
      else if (AVS_ADDRESS_I == dtdo_pkg::IRQ_MASK_OFS)
        irq_mask_reg <= wdata8;
    end
  end

  assign demod = mode_ctrl_reg[dtdo_pkg::DEMOD_BIT];
  assign pp_mode = ~demod & (mode_ctrl_reg[dtdo_pkg::SUB_LO+:2] == dtdo_pkg::SUB_PING_PONG);
  assign edge_hit = (mode_ctrl_reg[dtdo_pkg::LOGIC_LO+:2] == dtdo_pkg::EDGE_FALLING) ? pin_fall[0] :
                    (mode_ctrl_reg[dtdo_pkg::LOGIC_LO+:2] == dtdo_pkg::EDGE_RISING) ? pin_rise[0] :
                    (pin_rise[0] | pin_fall[0]);
  assign cap_evt = demod & (lstate_reg == dtdo_pkg::DTDO_L_RUN) & long_ctrl_reg[dtdo_pkg::EN_BIT] & edge_hit;
  assign s_tc = short_ctrl_reg[dtdo_pkg::EN_BIT] & short_run_reg & (short_cnt_reg == 8'h00);
  assign l_zero = (lstate_reg == dtdo_pkg::DTDO_L_RUN) & (long_cnt_reg == 16'h0000) & ~cap_evt;
  assign l_tc = l_zero & ~demod;
  assign long_cnt_inv = ~long_cnt_reg;

  // hardware enable changes beat a software write in the same cycle
  always_comb
  begin
    short_ctrl_next = wr_stc ? wdata8 : short_ctrl_reg;
    short_ctrl_next[dtdo_pkg::TIMEOUT_BIT] = dtdo_pkg::dtdo_w1c(short_ctrl_reg[dtdo_pkg::TIMEOUT_BIT], s_tc,
      wr_stc & wdata8[dtdo_pkg::TIMEOUT_BIT]);
    if (s_tc && (short_ctrl_reg[dtdo_pkg::SINGLE_BIT] || pp_mode))
      short_ctrl_next[dtdo_pkg::EN_BIT] = 1'b0;
    if (l_tc && pp_mode)
      short_ctrl_next[dtdo_pkg::EN_BIT] = 1'b1;
    long_ctrl_next = wr_ltc ? wdata8 : long_ctrl_reg;
    long_ctrl_next[dtdo_pkg::TIMEOUT_BIT] = dtdo_pkg::dtdo_w1c(long_ctrl_reg[dtdo_pkg::TIMEOUT_BIT], l_zero,
      wr_ltc & wdata8[dtdo_pkg::TIMEOUT_BIT]);
    if ((l_tc && (long_ctrl_reg[dtdo_pkg::SINGLE_BIT] || pp_mode)) ||
        (cap_evt && long_ctrl_reg[dtdo_pkg::SINGLE_BIT]))
      long_ctrl_next[dtdo_pkg::EN_BIT] = 1'b0;
    if (s_tc && pp_mode)
      long_ctrl_next[dtdo_pkg::EN_BIT] = 1'b1;
    mode_ctrl_next = wr_mode ? wdata8 : mode_ctrl_reg;
    if (demod)
    begin
      mode_ctrl_next[dtdo_pkg::RISE_BIT] = dtdo_pkg::dtdo_w1c(mode_ctrl_reg[dtdo_pkg::RISE_BIT],
        cap_evt & pin_rise[0], wr_mode & wdata8[dtdo_pkg::RISE_BIT]);
      mode_ctrl_next[dtdo_pkg::FALL_BIT] = dtdo_pkg::dtdo_w1c(mode_ctrl_reg[dtdo_pkg::FALL_BIT],
        cap_evt & pin_fall[0], wr_mode & wdata8[dtdo_pkg::FALL_BIT]);
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      short_ctrl_reg <= dtdo_pkg::CTRL_RST;
      mode_ctrl_reg <= dtdo_pkg::CTRL_RST;
      long_ctrl_reg <= dtdo_pkg::CTRL_RST;
    end
    else
    begin
      short_ctrl_reg <= short_ctrl_next;
      mode_ctrl_reg <= mode_ctrl_next;
      long_ctrl_reg <= long_ctrl_next;
    end
  end

  // short counter: down count, reload at zero, output toggles there
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      short_cnt_reg <= 8'h00;
      short_run_reg <= 1'b0;
      short_out_reg <= 1'b0;
    end
    else if (!short_ctrl_reg[dtdo_pkg::EN_BIT])
    begin
      short_run_reg <= 1'b0;
      short_out_reg <= ~mode_ctrl_reg[dtdo_pkg::RISE_BIT];
    end
    else if (!short_run_reg)
    begin
      short_cnt_reg <= short_reload_reg;
      short_run_reg <= 1'b1;
      short_out_reg <= mode_ctrl_reg[dtdo_pkg::RISE_BIT];
    end
    else if (s_tc)
    begin
      short_cnt_reg <= short_reload_reg;
      short_out_reg <= ~short_out_reg;
    end
    else
      short_cnt_reg <= short_cnt_reg - 8'h01;
  end

  // long counter: transmit runs straight away, demodulation waits for an edge
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      lstate_reg <= dtdo_pkg::DTDO_L_IDLE;
      long_cnt_reg <= 16'h0000;
      cap_reg <= 16'h0000;
    end
    else
    begin
      case (lstate_reg)
        dtdo_pkg::DTDO_L_IDLE:
        begin
          if (long_ctrl_reg[dtdo_pkg::EN_BIT] && demod)
            lstate_reg <= dtdo_pkg::DTDO_L_ARMED;
          else if (long_ctrl_reg[dtdo_pkg::EN_BIT])
          begin
            long_cnt_reg <= reload16_reg;
            lstate_reg <= dtdo_pkg::DTDO_L_RUN;
          end
        end
        dtdo_pkg::DTDO_L_ARMED:
        begin
          if (!long_ctrl_reg[dtdo_pkg::EN_BIT])
            lstate_reg <= dtdo_pkg::DTDO_L_IDLE;
          else if (edge_hit)
          begin
            long_cnt_reg <= dtdo_pkg::LONG_ALL_ONES;
            lstate_reg <= dtdo_pkg::DTDO_L_RUN;
          end
        end
        dtdo_pkg::DTDO_L_RUN:
        begin
          if (!long_ctrl_reg[dtdo_pkg::EN_BIT])
            lstate_reg <= dtdo_pkg::DTDO_L_IDLE;
          else if (cap_evt)
          begin
            cap_reg <= long_cnt_inv;
            long_cnt_reg <= dtdo_pkg::LONG_ALL_ONES;
          end
          else if (l_zero)
            long_cnt_reg <= demod ? dtdo_pkg::LONG_ALL_ONES : reload16_reg;
          else
            long_cnt_reg <= long_cnt_reg - 16'h0001;
        end
        default: lstate_reg <= dtdo_pkg::DTDO_L_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
      long_out_reg <= 1'b0;
    else if (!long_ctrl_reg[dtdo_pkg::EN_BIT])
      long_out_reg <= ~mode_ctrl_reg[dtdo_pkg::FALL_BIT];
    else if (lstate_reg == dtdo_pkg::DTDO_L_IDLE && !demod)
      long_out_reg <= mode_ctrl_reg[dtdo_pkg::FALL_BIT];
    else if (l_tc)
      long_out_reg <= ~long_out_reg;
  end

  // force sub-modes override the long output immediately
  assign long_val = (~demod && mode_ctrl_reg[dtdo_pkg::SUB_LO+:2] == dtdo_pkg::SUB_FORCE_LOW) ? 1'b0 :
                    (~demod && mode_ctrl_reg[dtdo_pkg::SUB_LO+:2] == dtdo_pkg::SUB_FORCE_HIGH) ? 1'b1 :
                    long_out_reg;
  assign combo = dtdo_pkg::dtdo_logic(mode_ctrl_reg[dtdo_pkg::LOGIC_LO+:2], short_out_reg, long_val);

  assign irq_src = {
    long_ctrl_reg[dtdo_pkg::LONG_INT_BIT] & (long_ctrl_reg[dtdo_pkg::TIMEOUT_BIT] |
      (demod & (mode_ctrl_reg[dtdo_pkg::RISE_BIT] | mode_ctrl_reg[dtdo_pkg::FALL_BIT]))),
    short_ctrl_reg[dtdo_pkg::SHORT_INT_BIT] & short_ctrl_reg[dtdo_pkg::TIMEOUT_BIT],
    pin_sync[6:3]
  };

  // pins and interrupts leave through flops; comparator routing wins on the shared pin
  always_ff @(posedge CORE_CLK_I or negedge RESETN_I)
  begin
    if (!RESETN_I)
    begin
      SHORT_TIMER_PIN_O <= 1'b0;
      LONG_TIMER_PIN_O <= 1'b0;
      COMBINED_TIMER_PIN_O <= 1'b0;
      COMPARATOR_SECOND_PIN_O <= 1'b0;
      IRQ_O <= 6'h00;
    end
    else
    begin
      SHORT_TIMER_PIN_O <= port_cfg_reg[dtdo_pkg::COMP_ROUTE_BIT] ? pin_sync[1] :
        short_ctrl_reg[dtdo_pkg::PIN_BIT] ? short_out_reg : PORT_OUT_I[0];
      LONG_TIMER_PIN_O <= long_ctrl_reg[dtdo_pkg::PIN_BIT] ? long_val : PORT_OUT_I[1];
      COMBINED_TIMER_PIN_O <= mode_ctrl_reg[dtdo_pkg::COMBINE_BIT] ? combo : PORT_OUT_I[2];
      COMPARATOR_SECOND_PIN_O <= port_cfg_reg[dtdo_pkg::COMP_ROUTE_BIT] ? pin_sync[2] : PORT_OUT_I[3];
      IRQ_O <= irq_mask_reg[dtdo_pkg::IRQ_GLOBAL_BIT] ? (irq_src & irq_mask_reg[5:0]) : 6'h00;
    end
  end

  assign AVS_WAITREQUEST_O = wait_reg;
  assign AVS_READDATA_O = rdata_reg;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);

  sequence short_ends_s;
    s_tc && pp_mode;
  endsequence
  sequence long_ends_s;
    l_tc && pp_mode;
  endsequence

  capture_value_a: assert property (cap_evt |=> cap_reg == $past(long_cnt_inv))
    else $error("capture does not hold inverted count");
  edge_status_a: assert property (cap_evt && pin_rise[0] |=> mode_ctrl_reg[dtdo_pkg::RISE_BIT])
    else $error("rising status not set on capture");
  capture_irq_a: assert property (cap_evt && long_ctrl_reg[dtdo_pkg::LONG_INT_BIT] &&
    irq_mask_reg[dtdo_pkg::IRQ_GLOBAL_BIT] && irq_mask_reg[dtdo_pkg::IRQ_LONG] && !wr_en
    |-> ##[1:2] IRQ_O[dtdo_pkg::IRQ_LONG])
    else $error("capture interrupt missing");
  capture_reload_a: assert property (cap_evt && long_ctrl_reg[dtdo_pkg::EN_BIT] |=>
    long_cnt_reg == dtdo_pkg::LONG_ALL_ONES ##1 long_cnt_reg == 16'hfffe)
    else $error("counter not reloaded with ones");
  ping_pong_a: assert property (short_ends_s |=> !short_ctrl_reg[dtdo_pkg::EN_BIT] &&
    long_ctrl_reg[dtdo_pkg::EN_BIT])
    else $error("ping-pong hand-over failed");
  pong_ping_a: assert property (long_ends_s |=> short_ctrl_reg[dtdo_pkg::EN_BIT] &&
    !long_ctrl_reg[dtdo_pkg::EN_BIT])
    else $error("pong-ping hand-over failed");
  timeout_set_a: assert property (s_tc |=> short_ctrl_reg[dtdo_pkg::TIMEOUT_BIT])
    else $error("short timeout bit not set");
  short_pin_a: assert property (!port_cfg_reg[dtdo_pkg::COMP_ROUTE_BIT] && short_ctrl_reg[dtdo_pkg::PIN_BIT]
    |=> SHORT_TIMER_PIN_O == $past(short_out_reg))
    else $error("short pin not driven by counter");
  long_pin_a: assert property (long_ctrl_reg[dtdo_pkg::PIN_BIT] |=> LONG_TIMER_PIN_O == $past(long_val))
    else $error("long pin not driven by counter");
  combined_pin_a: assert property (mode_ctrl_reg[dtdo_pkg::COMBINE_BIT] &&
    mode_ctrl_reg[dtdo_pkg::LOGIC_LO+:2] == dtdo_pkg::LOGIC_NOR
    |=> COMBINED_TIMER_PIN_O == !($past(short_out_reg) || $past(long_val)))
    else $error("combined pin wrong");
  irq_global_a: assert property (!irq_mask_reg[dtdo_pkg::IRQ_GLOBAL_BIT] |=> IRQ_O == 6'h00)
    else $error("interrupt passes global mask");
  comp_route_a: assert property (port_cfg_reg[dtdo_pkg::COMP_ROUTE_BIT]
    |=> COMPARATOR_SECOND_PIN_O == $past(pin_sync[2]))
    else $error("comparator not routed");
  first_edge_a: assert property (lstate_reg == dtdo_pkg::DTDO_L_ARMED && edge_hit &&
    long_ctrl_reg[dtdo_pkg::EN_BIT] |=> lstate_reg == dtdo_pkg::DTDO_L_RUN &&
    long_cnt_reg == dtdo_pkg::LONG_ALL_ONES)
    else $error("first edge did not start counter");
  edge_hold_a: assert property (demod && mode_ctrl_reg[dtdo_pkg::FALL_BIT] &&
    !(wr_mode && wdata8[dtdo_pkg::FALL_BIT]) |=> mode_ctrl_reg[dtdo_pkg::FALL_BIT])
    else $error("falling status lost");
  timeout_hold_a: assert property (long_ctrl_reg[dtdo_pkg::TIMEOUT_BIT] &&
    !(wr_ltc && wdata8[dtdo_pkg::TIMEOUT_BIT]) |=> long_ctrl_reg[dtdo_pkg::TIMEOUT_BIT])
    else $error("timeout cleared without a one");

endmodule : dtdo_top

// File: dtdo_carrier_model.sv
`timescale 1ns/1ps
module dtdo_carrier_model (
  input wire logic clk_i, // core clock
  input wire logic run_i, // carrier burst active
  input wire logic [7:0] half_i, // half period in clocks
  output logic carrier_o // modulated carrier pin
);
  logic [7:0] cnt_reg;
  initial
  begin
    carrier_o = 1'b0;
    cnt_reg = 8'h00;
  end
  // quiet carrier rests low, so a stop gives only a falling edge
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      carrier_o <= 1'b0;
      cnt_reg <= 8'h00;
    end
    else if (cnt_reg == half_i - 8'h01)
    begin
      carrier_o <= ~carrier_o; // evenly spaced edges, first one arms the count
      cnt_reg <= 8'h00;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule : dtdo_carrier_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clk, rst_n, rd_r, wr_r, run, lvi, wait_o, sp, lp, cp, c2;
  logic [7:0] addr, q;
  logic [31:0] wd, rdata;
  logic [3:0] be, pout;
  logic [1:0] comp;
  logic [2:0] p3;
  logic [5:0] irq;
  logic car;
  int fails, checks_done;
  logic e, f;
  logic [1:0] lg;
  logic [7:0] s1, l1, s2;
  dtdo_top dut_u (.CORE_CLK_I(clk), .RESETN_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_r),
    .AVS_WRITE_I(wr_r), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_o), .CARRIER_I(car), .COMP_I(comp), .PORT3_IRQ_I(p3), .LOW_VOLT_I(lvi),
    .PORT_OUT_I(pout), .SHORT_TIMER_PIN_O(sp), .LONG_TIMER_PIN_O(lp), .COMBINED_TIMER_PIN_O(cp),
    .COMPARATOR_SECOND_PIN_O(c2), .IRQ_O(irq));
  dtdo_carrier_model pm_u (.clk_i(clk), .run_i(run), .half_i(8'h14), .carrier_o(car));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize;
    if (fails == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    checks_done++;
    if (g !== x)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  // request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int n = 0;
    addr <= a;
    wd <= {24'h000000, d};
    if (w)
      wr_r <= 1'b1;
    else
      rd_r <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wait_o !== 1'b0 && n < 50);
    r = rdata[7:0];
    if (n >= 50)
    begin
      fails++;
      summarize();
    end
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    bus(1'b0, a, 8'h00, q);
    chk(q, x);
  endtask : rc
  initial
  begin
    #500000;
    fails++;
    summarize();
  end
  initial
  begin
    {rd_r, wr_r, run, lvi, addr, wd, comp, p3} = '0;
    be = 4'h1;
    pout = 4'ha;
    rst_n = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rc(dtdo_pkg::SHORT_CTRL_OFS, 8'h00);
    rc(dtdo_pkg::RELOAD_LOW_OFS, 8'hff);
    rc(8'h3c, 8'h00);
    be <= 4'h0;
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h40);
    be <= 4'h1;
    rc(dtdo_pkg::MODE_CTRL_OFS, 8'h00);
    // comparator routing on, then back to normal port data
    wr(dtdo_pkg::PORT_CFG_OFS, 8'h01);
    for (int i = 1; i < 3; i++)
    begin
      comp <= i[1:0];
      repeat (6) @(posedge clk);
      chk({6'h00, sp, c2}, {6'h00, i[0], i[1]});
    end
    rc(dtdo_pkg::PORT_CFG_OFS, 8'h00);
    wr(dtdo_pkg::PORT_CFG_OFS, 8'h00);
    repeat (4) @(posedge clk);
    chk({6'h00, sp, c2}, 8'h01);
    // idle short output is the inverse of its initial bit, long is forced
    wr(dtdo_pkg::SHORT_CTRL_OFS, 8'h01);
    wr(dtdo_pkg::LONG_CTRL_OFS, 8'h01);
    for (int k = 0; k < 8; k++)
    begin
      lg = k[2:1];
      f = k[0];
      e = (lg == 2'h0) ? f : (lg == 2'h1) ? 1'b1 : (lg == 2'h2) ? 1'b0 : ~f;
      wr(dtdo_pkg::MODE_CTRL_OFS, {2'b01, lg, 1'b1, f, 2'b00});
      repeat (4) @(posedge clk);
      chk({5'h00, sp, lp, cp}, {5'h00, 1'b1, f, e});
    end
    p3 <= 3'b101;
    lvi <= 1'b1;
    wr(dtdo_pkg::IRQ_MASK_OFS, 8'h8c);
    repeat (6) @(posedge clk);
    chk({2'b00, irq}, 8'h0c);
    rc(dtdo_pkg::IRQ_PEND_OFS, 8'h0d);
    wr(dtdo_pkg::IRQ_MASK_OFS, 8'h0c);
    repeat (4) @(posedge clk);
    chk({2'b00, irq}, 8'h00);
    p3 <= 3'b000;
    lvi <= 1'b0;
    // demodulation: rising edges every 40 clocks
    wr(dtdo_pkg::RELOAD_LOW_OFS, 8'hff);
    wr(dtdo_pkg::RELOAD_HIGH_OFS, 8'hff);
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h90);
    wr(dtdo_pkg::LONG_CTRL_OFS, 8'h84);
    wr(dtdo_pkg::IRQ_MASK_OFS, 8'ha0);
    run <= 1'b1;
    repeat (200) @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    rc(dtdo_pkg::CAP_HIGH_OFS, 8'h00);
    bus(1'b0, dtdo_pkg::CAP_LOW_OFS, 8'h00, q);
    chk({7'h00, q inside {[8'd37:8'd43]}}, 8'h01);
    chk({7'h00, irq[5]}, 8'h01);
    rc(dtdo_pkg::MODE_CTRL_OFS, 8'h92);
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h90);
    rc(dtdo_pkg::MODE_CTRL_OFS, 8'h92);
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h92);
    rc(dtdo_pkg::MODE_CTRL_OFS, 8'h90);
    chk({7'h00, irq[5]}, 8'h00);
    // falling edges only: four falls, the last three 40 clocks apart
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h80);
    run <= 1'b1;
    repeat (160) @(posedge clk);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    rc(dtdo_pkg::CAP_LOW_OFS, 8'h27);
    rc(dtdo_pkg::MODE_CTRL_OFS, 8'h81);
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h81);
    rc(dtdo_pkg::MODE_CTRL_OFS, 8'h80);
    wr(dtdo_pkg::LONG_CTRL_OFS, 8'h00);
    // ping-pong with 256-clock spans
    wr(dtdo_pkg::RELOAD_HIGH_OFS, 8'h00);
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h04);
    wr(dtdo_pkg::SHORT_CTRL_OFS, 8'h80);
    for (int k = 0; k < 6; k++)
    begin
      repeat (150) @(posedge clk);
      bus(1'b0, dtdo_pkg::SHORT_CTRL_OFS, 8'h00, s1);
      bus(1'b0, dtdo_pkg::LONG_CTRL_OFS, 8'h00, l1);
      bus(1'b0, dtdo_pkg::SHORT_CTRL_OFS, 8'h00, s2);
      chk({7'h00, (s1[7] ^ l1[7]) | (l1[7] ^ s2[7])}, 8'h01);
    end
    chk({6'h00, s2[5], l1[5]}, 8'h03);
    wr(dtdo_pkg::MODE_CTRL_OFS, 8'h00);
    wr(dtdo_pkg::LONG_CTRL_OFS, 8'h00);
    wr(dtdo_pkg::SHORT_CTRL_OFS, 8'h00);
    rc(dtdo_pkg::SHORT_CTRL_OFS, 8'h20);
    wr(dtdo_pkg::SHORT_CTRL_OFS, 8'h20);
    rc(dtdo_pkg::SHORT_CTRL_OFS, 8'h00);
    summarize();
  end
endmodule : testbench
